// ==== rtl/cdd_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
module cdd_engine #(
   parameter bit TO_HOST = 1'b1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output cdd_pkg::cdd_rs_req_type root_side_req,
   input wire logic root_side_ack,
   input wire logic [31:0] root_side_rdata,
   output cdd_pkg::cdd_ep_req_type ep_mem,
   input wire logic [31:0] ep_mem_rdata,
   output logic msi_req,
   input wire logic msi_ack,
   output logic irq
);
   // --------------------------------------------------
   // state
   // --------------------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_FETCH = 7'h02,
      ST_LAT = 7'h04,
      ST_SRC = 7'h08,
      ST_DST = 7'h10,
      ST_WB = 7'h20,
      ST_MSI = 7'h40
   } cdd_st_type;

   typedef struct packed {
      cdd_st_type st; // engine phase
      logic [31:0] ctrl; // header word 0
      logic [31:0] base_hi; // header word 1
      logic [31:0] base_lo; // header word 2
      logic [31:0] last; // header word 3
      logic [15:0] idx; // current descriptor
      logic [1:0] wcnt; // fetched word count
      logic [31:0] d_ctl; // descriptor word 0
      logic [31:0] d_ep; // descriptor word 1
      logic [31:0] d_hhi; // descriptor word 2
      logic [31:0] d_hlo; // descriptor word 3
      logic [15:0] cnt; // dwords moved
      logic [31:0] ep_ptr; // running endpoint address
      logic [63:0] h_ptr; // running host address
      logic [15:0] last_done; // last finished index
      logic [1:0] irq_status; // sticky events
      logic [1:0] irq_enable; // event mask
      logic msi; // msi request level
      cdd_pkg::cdd_rs_req_type rs; // host request
      cdd_pkg::cdd_ep_req_type ep; // endpoint strobes
      logic aw_ok; // write address held
      logic [7:0] aw_addr;
      logic w_ok; // write data held
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } cdd_state_type;

   cdd_state_type r;
   cdd_state_type next_r;
   logic wr_go; // write decode fires this cycle
   logic start; // last header word written

   // --------------------------------------------------
   // helpers
   // --------------------------------------------------
   // byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++)
         if (s[i])
            m[i*8 +: 8] = d[i*8 +: 8];
      return m;
   endfunction

   // address of word w of descriptor i
   function automatic logic [63:0] desc_addr(input logic [63:0] base, input logic [15:0] i,
                                             input logic [1:0] w);
      return base + cdd_pkg::TBL_DESC0 + {44'h0, i, 4'h0} + {60'h0, w, 2'h0};
   endfunction

   assign wr_go = r.aw_ok && r.w_ok && !r.bvalid;
   assign start = wr_go && (r.aw_addr == cdd_pkg::HDR_LAST);
   assign s_axi_awready = !r.aw_ok;
   assign s_axi_wready = !r.w_ok;
   assign s_axi_arready = !r.rvalid;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   assign root_side_req = r.rs;
   assign ep_mem = r.ep;
   assign msi_req = r.msi;
   assign irq = |(r.irq_status & r.irq_enable);

   // --------------------------------------------------
   // next-state logic
   // --------------------------------------------------
   always_comb
   begin
      logic [63:0] base;
      logic [1:0] irq_set;
      logic [1:0] irq_clr;
      logic issue;
      logic finish;
      logic post;
      logic next_d;
      logic fetch;
      base = {r.base_hi, r.base_lo};
      irq_set = 2'h0;
      irq_clr = 2'h0;
      issue = 1'b0;
      finish = 1'b0;
      post = 1'b0;
      next_d = 1'b0;
      fetch = 1'b0;
      next_r = r;
      next_r.ep.re = 1'b0;
      next_r.ep.we = 1'b0;
      // capture write address and data in either order
      if (s_axi_awvalid && !r.aw_ok)
      begin
         next_r.aw_ok = 1'b1;
         next_r.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !r.w_ok)
      begin
         next_r.w_ok = 1'b1;
         next_r.w_data = s_axi_wdata;
         next_r.w_strb = s_axi_wstrb;
      end
      // register write once both halves are held
      if (wr_go)
      begin
         next_r.aw_ok = 1'b0;
         next_r.w_ok = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = cdd_pkg::RESP_OKAY;
         unique case (r.aw_addr)
            cdd_pkg::HDR_CTRL: next_r.ctrl = merge(r.ctrl, r.w_data, r.w_strb);
            cdd_pkg::HDR_BASE_HI: next_r.base_hi = merge(r.base_hi, r.w_data, r.w_strb);
            cdd_pkg::HDR_BASE_LO: next_r.base_lo = merge(r.base_lo, r.w_data, r.w_strb);
            cdd_pkg::HDR_LAST: next_r.last = merge(r.last, r.w_data, r.w_strb);
            cdd_pkg::IRQ_CLEAR: irq_clr = r.w_strb[0] ? r.w_data[1:0] : 2'h0;
            cdd_pkg::IRQ_ENABLE:
            begin
               if (r.w_strb[0])
                  next_r.irq_enable = r.w_data[1:0];
            end
            cdd_pkg::IRQ_STATUS, cdd_pkg::ENG_STATUS: ; // read-only, ignored
            default: next_r.bresp = cdd_pkg::RESP_SLVERR; // unmapped
         endcase
      end
      if (r.bvalid && s_axi_bready)
         next_r.bvalid = 1'b0;
      // register read, answered one cycle later
      if (s_axi_arvalid && !r.rvalid)
      begin
         next_r.rvalid = 1'b1;
         next_r.rresp = cdd_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            cdd_pkg::HDR_CTRL: next_r.rdata = r.ctrl;
            cdd_pkg::HDR_BASE_HI: next_r.rdata = r.base_hi;
            cdd_pkg::HDR_BASE_LO: next_r.rdata = r.base_lo;
            cdd_pkg::HDR_LAST: next_r.rdata = r.last;
            cdd_pkg::IRQ_STATUS: next_r.rdata = {30'h0, r.irq_status};
            cdd_pkg::IRQ_ENABLE: next_r.rdata = {30'h0, r.irq_enable};
            cdd_pkg::IRQ_CLEAR: next_r.rdata = cdd_pkg::RST_WORD;
            cdd_pkg::ENG_STATUS:
            begin
               next_r.rdata = {16'h0, r.last_done};
               next_r.rdata[cdd_pkg::STS_IDLE_BIT] = (r.st == ST_IDLE);
               next_r.rdata[cdd_pkg::STS_BUSY_BIT] = (r.st != ST_IDLE);
            end
            default:
            begin
               next_r.rdata = cdd_pkg::RST_WORD;
               next_r.rresp = cdd_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (r.rvalid && s_axi_rready)
         next_r.rvalid = 1'b0;
      // engine sequence
      unique case (r.st)
         ST_IDLE:
         begin
            if (start)
            begin
               next_r.idx = 16'h0;
               fetch = 1'b1;
            end
         end
         ST_FETCH:
         begin
            // four dword reads, table never written here
            if (root_side_ack)
            begin
               unique case (r.wcnt)
                  2'h0: next_r.d_ctl = root_side_rdata;
                  2'h1: next_r.d_ep = root_side_rdata;
                  2'h2: next_r.d_hhi = root_side_rdata;
                  2'h3: next_r.d_hlo = root_side_rdata;
               endcase
               next_r.wcnt = r.wcnt + 2'h1;
               next_r.rs.addr = desc_addr(base, r.idx, r.wcnt + 2'h1);
               if (r.wcnt == 2'h3)
               begin
                  next_r.rs.valid = 1'b0;
                  next_r.cnt = 16'h0;
                  next_r.ep_ptr = r.d_ep;
                  next_r.h_ptr = {r.d_hhi, root_side_rdata};
                  if (r.d_ctl[15:0] == 16'h0)
                     finish = 1'b1;
                  else
                     issue = 1'b1;
               end
            end
         end
         ST_LAT:
            next_r.st = ST_SRC;
         ST_SRC:
         begin
            if (TO_HOST)
            begin
               // endpoint data is on the bus now
               next_r.rs.valid = 1'b1;
               next_r.rs.we = 1'b1;
               next_r.rs.addr = r.h_ptr;
               next_r.rs.wdata = ep_mem_rdata;
               next_r.st = ST_DST;
            end
            else if (root_side_ack)
            begin
               next_r.rs.valid = 1'b0;
               next_r.ep.we = 1'b1;
               next_r.ep.addr = r.ep_ptr;
               next_r.ep.wdata = root_side_rdata;
               next_r.st = ST_DST;
            end
         end
         ST_DST:
         begin
            // dword delivered: step both pointers
            if (!TO_HOST || root_side_ack)
            begin
               next_r.rs.valid = 1'b0;
               next_r.cnt = r.cnt + 16'h1;
               next_r.ep_ptr = r.ep_ptr + cdd_pkg::DW_STEP;
               next_r.h_ptr = r.h_ptr + {32'h0, cdd_pkg::DW_STEP};
               if (r.cnt + 16'h1 == r.d_ctl[15:0])
                  finish = 1'b1;
               else
                  issue = 1'b1;
            end
         end
         ST_WB:
         begin
            if (root_side_ack)
            begin
               next_r.rs.valid = 1'b0;
               post = 1'b1;
            end
         end
         ST_MSI:
         begin
            if (msi_ack)
            begin
               next_r.msi = 1'b0;
               next_d = 1'b1;
            end
         end
         default:
            next_r.st = ST_IDLE;
      endcase
      // start the next dword's source access
      if (issue)
      begin
         if (TO_HOST)
         begin
            next_r.ep.re = 1'b1;
            next_r.ep.addr = next_r.ep_ptr;
            next_r.st = ST_LAT;
         end
         else
         begin
            next_r.rs.valid = 1'b1;
            next_r.rs.we = 1'b0;
            next_r.rs.addr = next_r.h_ptr;
            next_r.st = ST_SRC;
         end
      end
      // transfer done: optional last-done write
      if (finish)
      begin
         if (r.d_ctl[cdd_pkg::DESC_WB_BIT] || r.ctrl[cdd_pkg::CTL_WB_BIT])
         begin
            next_r.rs.valid = 1'b1;
            next_r.rs.we = 1'b1;
            next_r.rs.addr = base + cdd_pkg::TBL_LAST_DONE;
            next_r.rs.wdata = {16'h0, r.idx};
            next_r.st = ST_WB;
         end
         else
            post = 1'b1;
      end
      // descriptor complete: record, then optional MSI
      if (post)
      begin
         next_r.last_done = r.idx;
         irq_set[cdd_pkg::IRQ_DESC] = 1'b1;
         if (r.d_ctl[cdd_pkg::DESC_IRQ_BIT] || r.ctrl[cdd_pkg::CTL_IRQ_BIT])
         begin
            next_r.msi = 1'b1;
            next_r.st = ST_MSI;
         end
         else
            next_d = 1'b1;
      end
      // step to the next descriptor or end the chain
      if (next_d)
      begin
         if (r.idx == r.last[15:0])
         begin
            irq_set[cdd_pkg::IRQ_CHAIN] = 1'b1;
            if (r.ctrl[cdd_pkg::CTL_LOOP_BIT])
            begin
               next_r.idx = 16'h0;
               fetch = 1'b1;
            end
            else
               next_r.st = ST_IDLE;
         end
         else
         begin
            next_r.idx = r.idx + 16'h1;
            fetch = 1'b1;
         end
      end
      // begin fetching descriptor next_r.idx
      if (fetch)
      begin
         next_r.wcnt = 2'h0;
         next_r.rs.valid = 1'b1;
         next_r.rs.we = 1'b0;
         next_r.rs.addr = desc_addr(base, next_r.idx, 2'h0);
         next_r.st = ST_FETCH;
      end
      // sticky events, a new event beats a clear
      next_r.irq_status = (r.irq_status & ~irq_clr) | irq_set;
   end

   // --------------------------------------------------
   // state register
   // --------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         r <= '0;
         r.st <= ST_IDLE;
      end
      else
         r <= next_r;
   end

   // --------------------------------------------------
   // checks
   // --------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_FETCH_READ: assert property ((r.st == ST_FETCH) |-> !r.rs.we)
      else $error("descriptor table written during fetch");
   AST_DESC_ADDR: assert property ((r.st == ST_FETCH) && r.rs.valid |->
      r.rs.addr == {r.base_hi, r.base_lo} + 64'h10 + {44'h0, r.idx, 4'h0} + {60'h0, r.wcnt, 2'h0})
      else $error("descriptor word address wrong");
   AST_WB_DATA: assert property ((r.st == ST_WB) |->
      r.rs.we && r.rs.addr == {r.base_hi, r.base_lo} + 64'hC && r.rs.wdata == {16'h0, r.idx})
      else $error("last-done write wrong");
   AST_MSI_HOLD: assert property (r.msi && !msi_ack |=> r.msi && r.st == ST_MSI)
      else $error("msi request dropped early");
   AST_START: assert property ((r.st == ST_IDLE) && start |=> (r.st == ST_FETCH) && r.idx == 16'h0)
      else $error("engine did not start on last header word");
   AST_ORDER: assert property ($rose(r.st == ST_FETCH) && !$past(r.st == ST_IDLE) |->
      r.idx == $past(r.idx) + 16'h1 || r.idx == 16'h0)
      else $error("descriptor index out of order");
   AST_HOST_BASE: assert property (r.rs.valid && (r.st == ST_SRC || r.st == ST_DST) && r.cnt == 16'h0 |->
      r.rs.addr == {r.d_hhi, r.d_hlo})
      else $error("host base address wrong");
   AST_EP_BASE: assert property ((r.ep.re || r.ep.we) && r.cnt == 16'h0 |-> r.ep.addr == r.d_ep)
      else $error("endpoint base address wrong");
   AST_LOOP_STOP: assert property ($rose(r.st == ST_IDLE) |-> !$past(r.ctrl[31]))
      else $error("engine stopped with loop enabled");

   COV_WB: cover property (r.st == ST_WB && root_side_ack);
   COV_MSI: cover property (r.msi && msi_ack);
   COV_LOOP: cover property ($rose(r.st == ST_FETCH) && r.idx == 16'h0 && !$past(r.st == ST_IDLE));
   COV_CHAIN_END: cover property ($rose(r.st == ST_IDLE));
endmodule
`default_nettype wire

// ==== rtl/cdd_pkg.sv ====
package cdd_pkg;
   // --------------------------------------------------
   // register byte offsets
   // --------------------------------------------------
   localparam logic [7:0] HDR_CTRL = 8'h00;
   localparam logic [7:0] HDR_BASE_HI = 8'h04;
   localparam logic [7:0] HDR_BASE_LO = 8'h08;
   localparam logic [7:0] HDR_LAST = 8'h0C;
   localparam logic [7:0] IRQ_STATUS = 8'h10;
   localparam logic [7:0] IRQ_CLEAR = 8'h14;
   localparam logic [7:0] IRQ_ENABLE = 8'h18;
   localparam logic [7:0] ENG_STATUS = 8'h1C;
   // --------------------------------------------------
   // descriptor table layout
   // --------------------------------------------------
   localparam logic [63:0] TBL_LAST_DONE = 64'h0000_0000_0000_000C;
   localparam logic [63:0] TBL_DESC0 = 64'h0000_0000_0000_0010;
   localparam logic [31:0] DW_STEP = 32'h0000_0004;
   // --------------------------------------------------
   // field positions
   // --------------------------------------------------
   localparam int CTL_IRQ_BIT = 17;
   localparam int CTL_WB_BIT = 18;
   localparam int CTL_LOOP_BIT = 31;
   localparam int DESC_IRQ_BIT = 16;
   localparam int DESC_WB_BIT = 17;
   localparam int STS_IDLE_BIT = 16;
   localparam int STS_BUSY_BIT = 17;
   localparam int IRQ_DESC = 0;
   localparam int IRQ_CHAIN = 1;
   // --------------------------------------------------
   // reset values and answers
   // --------------------------------------------------
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // --------------------------------------------------
   // carriers
   // --------------------------------------------------
   // dword request toward root-side memory
   typedef struct packed {
      logic valid;
      logic we;
      logic [63:0] addr;
      logic [31:0] wdata;
   } cdd_rs_req_type;
   // endpoint memory strobes, read data one cycle later
   typedef struct packed {
      logic re;
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } cdd_ep_req_type;
endpackage

// ==== test/cdd_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// root side memory, endpoint memory, msi sink
// ----------------------------------------
module cdd_host_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   input wire cdd_pkg::cdd_rs_req_type root_side_req,
   output logic root_side_ack,
   output logic [31:0] root_side_rdata,
   input wire cdd_pkg::cdd_ep_req_type ep_mem,
   output logic [31:0] ep_mem_rdata,
   input wire logic msi_req,
   output logic msi_ack
);
   logic [31:0] mem [logic [63:0]]; // root side memory, table and buffers
   logic [31:0] ep [logic [31:0]]; // endpoint memory
   int dly; // cycles the pending request has waited
   int msi_cnt; // interrupts taken
   // answer one dword request, three cycles late when slow
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         root_side_ack <= 1'h0;
         root_side_rdata <= 32'h0;
         dly <= 0;
      end
      else if (root_side_req.valid && !root_side_ack && dly >= (slow ? 3 : 0))
      begin
         root_side_ack <= 1'h1;
         dly <= 0;
         root_side_rdata <= mem[root_side_req.addr];
         if (root_side_req.we)
            mem[root_side_req.addr] = root_side_req.wdata;
      end
      else
      begin
         root_side_ack <= 1'h0;
         root_side_rdata <= ~root_side_rdata; // stale data inverts every cycle
         dly <= root_side_req.valid ? dly + 1 : 0;
      end
   end
   // endpoint memory and msi acceptance
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ep_mem_rdata <= 32'h0;
         msi_ack <= 1'h0;
         msi_cnt <= 0;
      end
      else
      begin
         ep_mem_rdata <= ep_mem.re ? ep[ep_mem.addr] : ~ep_mem_rdata;
         if (ep_mem.we)
            ep[ep_mem.addr] = ep_mem.wdata;
         msi_ack <= msi_req && !msi_ack;
         if (msi_req && !msi_ack)
            msi_cnt <= msi_cnt + 1;
      end
   end
endmodule
`default_nettype wire

// ==== test/cdd_engine_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module cdd_engine_bench;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, slow = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid, ack, msi_req, msi_ack, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, rs_rdata, ep_rdata;
   cdd_pkg::cdd_rs_req_type rs_req;
   cdd_pkg::cdd_ep_req_type ep_req;
   logic ack2, msi_req2, msi_ack2;
   logic [31:0] rs_rdata2, ep_rdata2;
   cdd_pkg::cdd_rs_req_type rs_req2;
   cdd_pkg::cdd_ep_req_type ep_req2;
   logic [95:0] exp_a[$], exp_h[$], exp_e[$]; // bus answers, root side writes, endpoint writes
   int failures = 0, checked = 0;
   logic [31:0] seed = 32'h6F66;
   localparam logic [63:0] TB = 64'h0000_0000_0000_1000; // table in one 4 KByte page
   localparam logic [63:0] HB = 64'h0000_0001_0000_2000; // data buffers
   cdd_engine #(.TO_HOST(1'b1)) cdd_engine_inst (.clk(clk), .rst(rst),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .root_side_req(rs_req), .root_side_ack(ack), .root_side_rdata(rs_rdata),
      .ep_mem(ep_req), .ep_mem_rdata(ep_rdata), .msi_req(msi_req), .msi_ack(msi_ack), .irq(irq));
   cdd_host_model cdd_host_model_inst (.clk(clk), .rst(rst), .slow(slow),
      .root_side_req(rs_req), .root_side_ack(ack), .root_side_rdata(rs_rdata),
      .ep_mem(ep_req), .ep_mem_rdata(ep_rdata), .msi_req(msi_req), .msi_ack(msi_ack));
   // read direction copy on the same register bus, its bus answers ignored
   cdd_engine #(.TO_HOST(1'b0)) cdd_engine_rd_inst (.clk(clk), .rst(rst),
      .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_bresp(),
      .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_araddr(araddr),
      .s_axi_rvalid(), .s_axi_rready(rready), .s_axi_rdata(), .s_axi_rresp(),
      .root_side_req(rs_req2), .root_side_ack(ack2), .root_side_rdata(rs_rdata2),
      .ep_mem(ep_req2), .ep_mem_rdata(ep_rdata2), .msi_req(msi_req2), .msi_ack(msi_ack2), .irq());
   cdd_host_model cdd_host_model_rd_inst (.clk(clk), .rst(rst), .slow(slow),
      .root_side_req(rs_req2), .root_side_ack(ack2), .root_side_rdata(rs_rdata2),
      .ep_mem(ep_req2), .ep_mem_rdata(ep_rdata2), .msi_req(msi_req2), .msi_ack(msi_ack2));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // oldest note, unknown when none is left
   function automatic logic [95:0] take(ref logic [95:0] q[$]);
      return q.size() > 0 ? q.pop_front() : {96{1'bx}};
   endfunction
   task automatic check(input logic [95:0] seen, input logic [95:0] want);
      checked++;
      if (seen !== want)
      begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // register write, both halves offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      exp_a.push_back({r, 32'h0});
      @(posedge clk);
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      awaddr <= a;
      wdata <= d;
      bready <= 1'h1;
      do
      begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'h0;
         if (wready)
            wvalid <= 1'h0;
      end
      while (!bvalid);
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      exp_a.push_back(e);
      @(posedge clk);
      arvalid <= 1'h1;
      araddr <= a;
      rready <= 1'h1;
      do
      begin
         @(posedge clk);
         if (arready)
            arvalid <= 1'h0;
      end
      while (!rvalid);
      rready <= 1'h0;
   endtask
   // one descriptor in root memory plus the writes it must cause
   task automatic desc(input int i, input int len, input logic [1:0] fl, input logic [31:0] epa, input logic wb);
      logic [63:0] h;
      logic [63:0] d;
      h = HB + 64'(i) * 64'h400;
      d = TB + 64'h10 + 64'(i) * 64'h10;
      cdd_host_model_inst.mem[d] = {14'h0, fl, 16'(len)};
      cdd_host_model_inst.mem[d + 64'h4] = epa;
      cdd_host_model_inst.mem[d + 64'h8] = h[63:32];
      cdd_host_model_inst.mem[d + 64'hC] = h[31:0];
      for (int w = 0; w < 4; w++)
         cdd_host_model_rd_inst.mem[d + 64'(4 * w)] = cdd_host_model_inst.mem[d + 64'(4 * w)];
      for (int k = 0; k < len; k++)
      begin
         cdd_host_model_inst.ep[epa + 32'(4 * k)] = rnd();
         cdd_host_model_rd_inst.mem[h + 64'(4 * k)] = cdd_host_model_inst.ep[epa + 32'(4 * k)];
         exp_e.push_back({epa + 32'(4 * k), cdd_host_model_inst.ep[epa + 32'(4 * k)]});
         exp_h.push_back({h + 64'(4 * k), cdd_host_model_inst.ep[epa + 32'(4 * k)]});
      end
      if (wb)
         exp_h.push_back({TB + 64'hC, 16'h0, 16'(i)});
   endtask
   // header in order, nothing fetched before the last word
   task automatic run(input logic [31:0] ctl, input logic [15:0] last);
      wr(cdd_pkg::HDR_CTRL, ctl, cdd_pkg::RESP_OKAY);
      wr(cdd_pkg::HDR_BASE_HI, TB[63:32], cdd_pkg::RESP_OKAY);
      wr(cdd_pkg::HDR_BASE_LO, TB[31:0], cdd_pkg::RESP_OKAY);
      check(96'(rs_req.valid), 96'h0);
      wr(cdd_pkg::HDR_LAST, {16'h0, last}, cdd_pkg::RESP_OKAY);
   endtask
   // ----------------------------------------
   // clock, monitor, watchdog
   // ----------------------------------------
   initial
   begin
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (bvalid && bready)
         check({bresp, 32'h0}, take(exp_a));
      if (rvalid && rready)
         check({rresp, rdata}, take(exp_a));
      if (rs_req.valid && rs_req.we && ack)
         check({rs_req.addr, rs_req.wdata}, take(exp_h));
      if (ep_req2.we)
         check({ep_req2.addr, ep_req2.wdata}, take(exp_e));
   end
   initial
   begin
      repeat (30000) @(posedge clk);
      failures++;
      finish_test();
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      rd(cdd_pkg::HDR_CTRL, {cdd_pkg::RESP_OKAY, cdd_pkg::RST_WORD});
      rd(cdd_pkg::ENG_STATUS, {cdd_pkg::RESP_OKAY, 32'h0001_0000});
      wr(8'h40, 32'h1, cdd_pkg::RESP_SLVERR);
      wr(cdd_pkg::IRQ_STATUS, 32'h3, cdd_pkg::RESP_OKAY);
      rd(cdd_pkg::IRQ_STATUS, {cdd_pkg::RESP_OKAY, 32'h0});
      wr(cdd_pkg::IRQ_ENABLE, 32'h2, cdd_pkg::RESP_OKAY);
      // per-descriptor flags only, zero-length middle descriptor
      desc(0, 2, 2'b10, 32'h40, 1'h1);
      desc(1, 0, 2'b01, 32'h80, 1'h0);
      desc(2, 3, 2'b00, 32'h100, 1'h0);
      run(32'h0000_0003, 16'h2);
      wait (irq === 1'h1);
      check(96'(cdd_host_model_inst.msi_cnt), 96'h1);
      check(96'(exp_h.size()), 96'h0);
      check(96'(exp_e.size()), 96'h0);
      check(96'(cdd_host_model_inst.mem[TB + 64'h10]), 96'h0002_0002);
      check(96'(cdd_host_model_inst.mem[TB + 64'hC]), 96'h0);
      rd(cdd_pkg::ENG_STATUS, {cdd_pkg::RESP_OKAY, 32'h0001_0002});
      rd(cdd_pkg::IRQ_STATUS, {cdd_pkg::RESP_OKAY, 32'h3});
      wr(cdd_pkg::IRQ_CLEAR, 32'h3, cdd_pkg::RESP_OKAY);
      check(96'(irq), 96'h0);
      // global enables, slow root side
      slow <= 1'h1;
      desc(0, 1, 2'b00, 32'h140, 1'h1);
      desc(1, 2, 2'b00, 32'h180, 1'h1);
      run(32'h0006_0002, 16'h1);
      wait (irq === 1'h1);
      check(96'(cdd_host_model_inst.msi_cnt), 96'h3);
      check(96'(exp_h.size()), 96'h0);
      check(96'(exp_e.size()), 96'h0);
      check(96'(cdd_host_model_inst.mem[TB + 64'hC]), 96'h1);
      wr(cdd_pkg::IRQ_CLEAR, 32'h3, cdd_pkg::RESP_OKAY);
      // endless chain, stopped by clearing the loop bit
      slow <= 1'h0;
      desc(0, 1, 2'b11, 32'h200, 1'h1);
      for (int j = 0; j < 20; j++)
      begin
         exp_h.push_back({HB, cdd_host_model_inst.ep[32'h200]});
         exp_h.push_back({TB + 64'hC, 32'h0});
         exp_e.push_back({32'h200, cdd_host_model_inst.ep[32'h200]});
      end
      run(32'h8000_0001, 16'h0);
      wait (cdd_host_model_inst.msi_cnt >= 6);
      wr(cdd_pkg::HDR_CTRL, 32'h0000_0001, cdd_pkg::RESP_OKAY);
      // chain end already fired while looping; let the pass under way finish
      repeat (40) @(posedge clk);
      check(96'(irq), 96'h1);
      check(96'(exp_h.size() % 2), 96'h0);
      exp_h.delete();
      exp_e.delete();
      rd(cdd_pkg::ENG_STATUS, {cdd_pkg::RESP_OKAY, 32'h0001_0000});
      finish_test();
   end
endmodule
`default_nettype wire
